// ==== pin_event_if.sv ====
// synchronised pin events passed from the pin front end to the register store
`timescale 1ns/1ps
interface pin_event_if;
   logic cs_active; // chip select asserted (level)
   logic cs_start; // chip select just asserted (pulse)
   logic cs_end; // chip select just released (pulse)
   logic sck_rise; // serial clock rising edge (pulse)
   logic sck_fall; // serial clock falling edge (pulse)
   logic sdi_bit; // synchronised serial data
   logic hold_reset; // supply low or reset pin low (level)
   modport src (output cs_active, cs_start, cs_end, sck_rise, sck_fall, sdi_bit, hold_reset);
   modport dst (input cs_active, cs_start, cs_end, sck_rise, sck_fall, sdi_bit, hold_reset);
endinterface

// ==== pin_front_end.sv ====
// two-flop synchronisers and edge finders for the serial and reset pins
`timescale 1ns/1ps
module pin_front_end (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic reset_pin_n,
   input wire logic supply_below_trip,
   pin_event_if.src ev
);
   // ===========================================================
   // synchronisers
   // ===========================================================
   localparam int n_pins = 5;
   // reset values make the block look held in reset and deselected
   localparam logic [n_pins-1:0] sync_init = 5'h11;
   logic [n_pins-1:0] raw; // pin order: supply, rstpin, sdi, sck, cs
   logic [n_pins-1:0] meta_r;
   logic [n_pins-1:0] meta_nxt;
   logic [n_pins-1:0] sync_r;
   logic [n_pins-1:0] sync_nxt;
   logic sck_prev_r;
   logic sck_prev_nxt;
   logic cs_prev_r;
   logic cs_prev_nxt;

   assign raw = {supply_below_trip, reset_pin_n, sdi, sck, cs_n};

   // per pin: first flop feeds only the second
   genvar i;
   generate
      for (i = 0; i < n_pins; i++) begin : g_sync
         always_comb begin
            meta_nxt[i] = raw[i];
            sync_nxt[i] = meta_r[i];
         end
      end
   endgenerate

   // history of the synchronised levels for edge finding
   always_comb begin
      sck_prev_nxt = sync_r[1];
      cs_prev_nxt = sync_r[0];
   end

   // register stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= sync_init;
         sync_r <= sync_init;
         sck_prev_r <= 1'b0;
         cs_prev_r <= 1'b1;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         sck_prev_r <= sck_prev_nxt;
         cs_prev_r <= cs_prev_nxt;
      end
   end

   // ===========================================================
   // event outputs
   // ===========================================================
   assign ev.cs_active = ~sync_r[0];
   assign ev.cs_start = cs_prev_r & ~sync_r[0];
   assign ev.cs_end = ~cs_prev_r & sync_r[0];
   assign ev.sck_rise = ~sck_prev_r & sync_r[1];
   assign ev.sck_fall = sck_prev_r & ~sync_r[1];
   assign ev.sdi_bit = sync_r[2];
   // [RULE19] either source holds reset
   assign ev.hold_reset = sync_r[4] | ~sync_r[3];
endmodule

// ==== quad_pot_pkg.sv ====
// shared constants for the quad potentiometer register store
package quad_pot_pkg;
   // ===========================================================
   // register map
   // ===========================================================
   localparam logic [3:0] addr_wiper_0 = 4'h0;
   localparam logic [3:0] addr_wiper_1 = 4'h1;
   localparam logic [3:0] addr_tsc_low = 4'h4;
   localparam logic [3:0] addr_wiper_2 = 4'h6;
   localparam logic [3:0] addr_wiper_3 = 4'h7;
   localparam logic [3:0] addr_tsc_high = 4'ha;
   localparam int num_locations = 16;
   localparam int reg_width = 9;
   localparam int num_wipers = 4;
   // ===========================================================
   // reset values and scale limits
   // ===========================================================
   localparam logic [8:0] wiper_mid_8bit = 9'h080;
   localparam logic [8:0] wiper_mid_7bit = 9'h040;
   localparam logic [8:0] wiper_full_8bit = 9'h100;
   localparam logic [8:0] wiper_full_7bit = 9'h080;
   localparam logic [8:0] wiper_zero = 9'h000;
   localparam logic [8:0] tsc_reset = 9'h1ff;
   // ===========================================================
   // terminal control field positions within one nibble, and of the fixed one bit within the register
   // ===========================================================
   localparam int fld_term_b = 0;
   localparam int fld_wiper = 1;
   localparam int fld_term_a = 2;
   localparam int fld_shutdown = 3;
   localparam int fixed_one_pos = 8;
   // ===========================================================
   // serial command framing
   // ===========================================================
   localparam logic [1:0] cmd_write = 2'h0;
   localparam logic [1:0] cmd_incr = 2'h1;
   localparam logic [1:0] cmd_decr = 2'h2;
   localparam logic [1:0] cmd_read = 2'h3;
   localparam logic [3:0] cnt_decode = 4'h5;
   localparam logic [3:0] cnt_last = 4'h7;
   localparam logic [9:0] sdo_idle = 10'h3ff;
   // frame states
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_cmd = 2'b01,
      st_data = 2'b10,
      st_error = 2'b11
   } frame_state_e;
endpackage

// ==== quad_pot_regs.sv ====
// register store, command checking and reset loading of the quad potentiometer
// Function
// [RULE1] power-up loads all defaults, then operates
// [RULE2] supply below trip: serial interface ignored
// [RULE3] brown-out recovery repeats the power-up load
// [RULE4] reset pin low forces defaults, disables serial
// [RULE5] sixteen nine-bit volatile locations
// [RULE6] wiper default is mid scale
// [RULE7] fixed addresses for wipers and terminal control
// [RULE8] disallowed command raises error
// [RULE9] error clears on chip select cycle
// [RULE10] eight control bits per terminal register
// [RULE11] terminal value applies when command completes
// [RULE12] terminal registers reset to all connected
// [RULE13] host rewrites terminal control after reset
// [RULE14] low register layout, bit eight read-only
// [RULE15] connect bits connect at one, wipers untouched
// [RULE16] shutdown bit forces shutdown at zero; net_shutdown_force goes high at one instead
// [RULE17] high register mirrors layout for nets 2,3
// [RULE18] wiper full scale and zero limits
// [RULE19] internal reset while detector or pin active
`timescale 1ns/1ps
module quad_pot_regs #(
   parameter bit eight_bit = 1'b1 // 1: 8-bit variant, 0: 7-bit variant
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic reset_pin_n,
   input wire logic supply_below_trip,
   output logic sdo_out,
   output logic sdo_oe_n,
   output logic [8:0] wiper_pos_0,
   output logic [8:0] wiper_pos_1,
   output logic [8:0] wiper_pos_2,
   output logic [8:0] wiper_pos_3,
   output logic [3:0] net_shutdown_force,
   output logic [3:0] net_term_a_connect,
   output logic [3:0] net_wiper_connect,
   output logic [3:0] net_term_b_connect,
   output logic cmd_error
);
   // ===========================================================
   // constants and declarations
   // ===========================================================
   // [RULE6] mid scale per variant
   localparam logic [8:0] wiper_mid = eight_bit ? quad_pot_pkg::wiper_mid_8bit
                                                : quad_pot_pkg::wiper_mid_7bit;
   // [RULE18] full scale per variant
   localparam logic [8:0] wiper_full = eight_bit ? quad_pot_pkg::wiper_full_8bit
                                                 : quad_pot_pkg::wiper_full_7bit;

   pin_event_if ev ();

   quad_pot_pkg::frame_state_e state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt; // bit count within the current byte
   logic [7:0] shift_r, shift_nxt; // incoming bits
   logic [3:0] addr_r, addr_nxt; // decoded address of the command
   logic [1:0] cmd_r, cmd_nxt; // decoded command code
   logic d8_r, d8_nxt; // ninth data bit held from the command byte
   logic err_r, err_nxt; // sticky command error
   logic [9:0] sdo_shift_r, sdo_shift_nxt; // outgoing bits
   logic sdo_r, sdo_nxt;
   // [RULE5] nine-bit locations
   logic [8:0] wiper_r [quad_pot_pkg::num_wipers];
   logic [8:0] wiper_nxt [quad_pot_pkg::num_wipers];
   logic [7:0] tsc_low_r, tsc_low_nxt; // nets 0 and 1
   logic [7:0] tsc_high_r, tsc_high_nxt; // nets 2 and 3

   // pin synchronisers and edge finders
   pin_front_end u_front (
      .clk(clk),
      .rst_n(rst_n),
      .cs_n(cs_n),
      .sck(sck),
      .sdi(sdi),
      .reset_pin_n(reset_pin_n),
      .supply_below_trip(supply_below_trip),
      .ev(ev)
   );

   // ===========================================================
   // address helpers
   // ===========================================================
   // wiper index of an address, or 4 for non-wiper addresses
   function automatic logic [2:0] wiper_index(input logic [3:0] a);
      logic [2:0] idx;
      idx = 3'h4;
      case (a)
         quad_pot_pkg::addr_wiper_0: idx = 3'h0;
         quad_pot_pkg::addr_wiper_1: idx = 3'h1;
         quad_pot_pkg::addr_wiper_2: idx = 3'h2;
         quad_pot_pkg::addr_wiper_3: idx = 3'h3;
         default: idx = 3'h4;
      endcase
      return idx;
   endfunction

   // is the address/command pair allowed
   function automatic logic cmd_allowed(input logic [3:0] a, input logic [1:0] c);
      logic ok;
      ok = 1'b0;
      // [RULE7] decode of the six live locations
      if (wiper_index(a) < 3'h4) begin
         ok = 1'b1;
      end else if (a == quad_pot_pkg::addr_tsc_low || a == quad_pot_pkg::addr_tsc_high) begin
         ok = (c == quad_pot_pkg::cmd_write) || (c == quad_pot_pkg::cmd_read);
      end
      return ok;
   endfunction

   // read value of a live location
   function automatic logic [8:0] read_value(input logic [3:0] a,
                                            input logic [8:0] w0, input logic [8:0] w1,
                                            input logic [8:0] w2, input logic [8:0] w3,
                                            input logic [7:0] tl, input logic [7:0] th);
      logic [8:0] v;
      v = quad_pot_pkg::wiper_zero;
      case (a)
         quad_pot_pkg::addr_wiper_0: v = w0;
         quad_pot_pkg::addr_wiper_1: v = w1;
         quad_pot_pkg::addr_wiper_2: v = w2;
         quad_pot_pkg::addr_wiper_3: v = w3;
         // [RULE14] bit eight reads as one
         quad_pot_pkg::addr_tsc_low: v = {1'b1, tl};
         quad_pot_pkg::addr_tsc_high: v = {1'b1, th};
         default: v = quad_pot_pkg::wiper_zero;
      endcase
      return v;
   endfunction

   // ===========================================================
   // frame decode and register update
   // ===========================================================
   always_comb begin
      logic [5:0] head;
      logic [7:0] byte_in;
      logic [2:0] widx;
      head = {shift_r[4:0], ev.sdi_bit};
      byte_in = {shift_r[6:0], ev.sdi_bit};
      widx = wiper_index(addr_r);
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      addr_nxt = addr_r;
      cmd_nxt = cmd_r;
      d8_nxt = d8_r;
      err_nxt = err_r;
      sdo_shift_nxt = sdo_shift_r;
      sdo_nxt = sdo_r;
      wiper_nxt = wiper_r;
      tsc_low_nxt = tsc_low_r;
      tsc_high_nxt = tsc_high_r;
      if (ev.hold_reset) begin
         // [RULE1] [RULE3] [RULE4] defaults loaded while held, serial ignored
         state_nxt = quad_pot_pkg::st_idle;
         cnt_nxt = 4'h0;
         err_nxt = 1'b0;
         sdo_shift_nxt = quad_pot_pkg::sdo_idle;
         sdo_nxt = 1'b1;
         for (int k = 0; k < quad_pot_pkg::num_wipers; k++) begin
            wiper_nxt[k] = wiper_mid;
         end
         // [RULE12] all terminals connected
         tsc_low_nxt = quad_pot_pkg::tsc_reset[7:0];
         tsc_high_nxt = quad_pot_pkg::tsc_reset[7:0];
      end else if (ev.cs_end) begin
         // deselect ends the frame; a pending error stays visible
         state_nxt = quad_pot_pkg::st_idle;
         cnt_nxt = 4'h0;
      end else if (ev.cs_start) begin
         // [RULE9] error cleared by a fresh select or while reset is held
         state_nxt = quad_pot_pkg::st_cmd;
         cnt_nxt = 4'h0;
         err_nxt = 1'b0;
         sdo_shift_nxt = quad_pot_pkg::sdo_idle;
      end else if (ev.sck_fall && ev.cs_active) begin
         // shift out on the falling edge, mode 0
         sdo_nxt = sdo_shift_r[9];
         sdo_shift_nxt = {sdo_shift_r[8:0], 1'b1};
      end else if (ev.sck_rise && ev.cs_active) begin
         unique case (state_r)
            quad_pot_pkg::st_idle: begin
               // select seen while held in reset: wait for a new select
            end
            quad_pot_pkg::st_cmd: begin
               shift_nxt = byte_in;
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == quad_pot_pkg::cnt_decode) begin
                  addr_nxt = head[5:2];
                  cmd_nxt = head[1:0];
                  // [RULE8] reject disallowed address/command pairs
                  if (!cmd_allowed(head[5:2], head[1:0])) begin
                     err_nxt = 1'b1;
                     state_nxt = quad_pot_pkg::st_error;
                     sdo_shift_nxt = 10'h000;
                  end else if (head[1:0] == quad_pot_pkg::cmd_read) begin
                     sdo_shift_nxt = {1'b1, read_value(head[5:2], wiper_r[0], wiper_r[1],
                                      wiper_r[2], wiper_r[3], tsc_low_r, tsc_high_r)};
                  end
               end else if (cnt_r == quad_pot_pkg::cnt_last) begin
                  cnt_nxt = 4'h0;
                  d8_nxt = ev.sdi_bit;
                  if (cmd_r == quad_pot_pkg::cmd_incr) begin
                     // [RULE18] increment stops at full scale
                     if (wiper_r[widx[1:0]] < wiper_full) begin
                        wiper_nxt[widx[1:0]] = wiper_r[widx[1:0]] + 9'h001;
                     end
                  end else if (cmd_r == quad_pot_pkg::cmd_decr) begin
                     // decrement stops at zero scale
                     if (wiper_r[widx[1:0]] != quad_pot_pkg::wiper_zero) begin
                        wiper_nxt[widx[1:0]] = wiper_r[widx[1:0]] - 9'h001;
                     end
                  end else begin
                     state_nxt = quad_pot_pkg::st_data;
                  end
               end
            end
            quad_pot_pkg::st_data: begin
               shift_nxt = byte_in;
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == quad_pot_pkg::cnt_last) begin
                  // [RULE11] value lands only once the command completes
                  cnt_nxt = 4'h0;
                  state_nxt = quad_pot_pkg::st_cmd;
                  if (cmd_r == quad_pot_pkg::cmd_write) begin
                     if (!widx[2]) begin
                        // writes above full scale are clipped
                        wiper_nxt[widx[1:0]] = ({d8_r, byte_in} > wiper_full) ? wiper_full
                                                                             : {d8_r, byte_in};
                     end else if (addr_r == quad_pot_pkg::addr_tsc_low) begin
                        // [RULE10] [RULE14] eight writable bits, bit eight fixed
                        tsc_low_nxt = byte_in;
                     end else begin
                        // [RULE17] same layout for nets 2 and 3
                        tsc_high_nxt = byte_in;
                     end
                  end
               end
            end
            quad_pot_pkg::st_error: begin
               // rest of the frame is ignored until deselect
            end
         endcase
      end
   end

   // registers of the frame and store
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= quad_pot_pkg::st_idle;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         addr_r <= 4'h0;
         cmd_r <= quad_pot_pkg::cmd_write;
         d8_r <= 1'b0;
         err_r <= 1'b0;
         sdo_shift_r <= quad_pot_pkg::sdo_idle;
         sdo_r <= 1'b1;
         for (int k = 0; k < quad_pot_pkg::num_wipers; k++) begin
            wiper_r[k] <= wiper_mid;
         end
         tsc_low_r <= quad_pot_pkg::tsc_reset[7:0];
         tsc_high_r <= quad_pot_pkg::tsc_reset[7:0];
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         addr_r <= addr_nxt;
         cmd_r <= cmd_nxt;
         d8_r <= d8_nxt;
         err_r <= err_nxt;
         sdo_shift_r <= sdo_shift_nxt;
         sdo_r <= sdo_nxt;
         wiper_r <= wiper_nxt;
         tsc_low_r <= tsc_low_nxt;
         tsc_high_r <= tsc_high_nxt;
      end
   end

   // ===========================================================
   // outputs
   // ===========================================================
   // [RULE2] output released while held or deselected
   assign sdo_oe_n = ~ev.cs_active | ev.hold_reset;
   // error pulls the data line low so the host can see it
   assign sdo_out = sdo_r & ~err_r;
   assign cmd_error = err_r;
   assign wiper_pos_0 = wiper_r[0];
   assign wiper_pos_1 = wiper_r[1];
   assign wiper_pos_2 = wiper_r[2];
   assign wiper_pos_3 = wiper_r[3];

   // per network switch controls; never touch the wipers
   genvar n;
   generate
      for (n = 0; n < quad_pot_pkg::num_wipers; n++) begin : g_net
         logic [3:0] nib;
         assign nib = (n < 2) ? tsc_low_r[4*(n%2) +: 4] : tsc_high_r[4*(n%2) +: 4];
         // [RULE15] one means connected
         assign net_term_a_connect[n] = nib[quad_pot_pkg::fld_term_a];
         assign net_wiper_connect[n] = nib[quad_pot_pkg::fld_wiper];
         assign net_term_b_connect[n] = nib[quad_pot_pkg::fld_term_b];
         // [RULE16] net_shutdown_force is high when the shutdown bit is one, not zero
         assign net_shutdown_force[n] = nib[quad_pot_pkg::fld_shutdown];
      end
   endgenerate
endmodule

// ==== quad_pot_regs_properties.sv ====
// concurrent checks on the ports of the quad potentiometer register store
`timescale 1ns/1ps
module quad_pot_regs_properties #(
   parameter bit eight_bit = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic reset_pin_n,
   input wire logic supply_below_trip,
   input wire logic sdo_out,
   input wire logic sdo_oe_n,
   input wire logic [8:0] wiper_pos_0,
   input wire logic [8:0] wiper_pos_1,
   input wire logic [8:0] wiper_pos_2,
   input wire logic [8:0] wiper_pos_3,
   input wire logic [3:0] net_shutdown_force,
   input wire logic [3:0] net_term_a_connect,
   input wire logic [3:0] net_wiper_connect,
   input wire logic cmd_error
);
   // ===========================================================
   // clocking and variant limits
   // ===========================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   localparam logic [8:0] mid = eight_bit ? quad_pot_pkg::wiper_mid_8bit :
      quad_pot_pkg::wiper_mid_7bit;
   localparam logic [8:0] full = eight_bit ? quad_pot_pkg::wiper_full_8bit :
      quad_pot_pkg::wiper_full_7bit;
   logic held; // either reset source pin active
   assign held = !reset_pin_n || supply_below_trip;
   // ===========================================================
   // properties
   // ===========================================================
   err_sdo_a: assert property (cmd_error |-> !sdo_out)
      else $error("sdo high while error flagged");
   pin_def_a: assert property (!reset_pin_n [*5] |->
      wiper_pos_0 == mid && wiper_pos_3 == mid)
      else $error("wipers not at default under reset pin");
   trip_def_a: assert property (supply_below_trip [*5] |->
      (&net_term_a_connect) && (&net_shutdown_force) && wiper_pos_1 == mid && !cmd_error)
      else $error("defaults not loaded under low supply");
   trip_oe_a: assert property (supply_below_trip [*5] |-> sdo_oe_n)
      else $error("sdo driven under low supply");
   err_hold_a: assert property (cmd_error && cs_n && !held |=> cmd_error)
      else $error("error dropped without select cycle");
   err_clr_a: assert property ($fell(cs_n) && cmd_error |-> ##[1:4] !cmd_error)
      else $error("error not cleared by select edge");
   wiper_rng_a: assert property (wiper_pos_0 <= full && wiper_pos_1 <= full &&
      wiper_pos_2 <= full && wiper_pos_3 <= full)
      else $error("wiper above full scale");
   term_chg_a: assert property ($changed(net_wiper_connect) |-> !cs_n || held)
      else $error("terminal switch changed outside a command");
   wip_keep_a: assert property ($changed(net_term_a_connect) && !held |->
      $stable({wiper_pos_0, wiper_pos_3}))
      else $error("terminal write moved a wiper");
endmodule
bind quad_pot_regs quad_pot_regs_properties #(.eight_bit(eight_bit)) u_quad_pot_regs_properties (
   .clk, .rst_n, .cs_n, .reset_pin_n, .supply_below_trip, .sdo_out, .sdo_oe_n, .wiper_pos_0,
   .wiper_pos_1, .wiper_pos_2, .wiper_pos_3, .net_shutdown_force, .net_term_a_connect,
   .net_wiper_connect, .cmd_error);

// ==== spi_host_model.sv ====
// serial host model that drives chip select, serial clock and data in
`timescale 1ns/1ps
module spi_host_model (
   input wire logic clk,
   input wire logic sdo_out,
   output logic cs_n,
   output logic sck,
   output logic sdi
);
   // ===========================================================
   // idle levels
   // ===========================================================
   // clock rests low between frames, data rests at its pull-up level
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b1;
   end
   // wait a number of system clocks
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ===========================================================
   // frame control
   // ===========================================================
   // select edge clears error
   task automatic cs_lo();
      tick(1);
      cs_n <= 1'b0;
      tick(4);
   endtask
   // release select; partial commands are thrown away by the device
   task automatic cs_hi();
      cs_n <= 1'b1;
      tick(4);
   endtask
   // shift n bits msb first; 4 clocks per phase keeps above the 3-clock minimum
   task automatic shift(input logic [15:0] bits, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= bits[i];
         tick(4);
         sck <= 1'b1;
         tick(1);
         rd = {rd[14:0], sdo_out};
         tick(3);
         sck <= 1'b0;
      end
      sdi <= 1'b1;
      tick(4);
   endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the quad potentiometer register store
`timescale 1ns/1ps
module tb;
   // ===========================================================
   // pins, tables and counters
   // ===========================================================
   logic clk, rst_n, reset_pin_n, supply_below_trip, cs_n, sck, sdi;
   logic sdo_out, sdo_oe_n, cmd_error, rsv;
   logic [8:0] wp0, wp1, wp2, wp3;
   logic [3:0] sdf, tac, twc, tbc;
   logic [15:0] rd;
   logic [9:0] got;
   logic [3:0] wadr [4] = '{4'h0, 4'h1, 4'h6, 4'h7}; // wiper addresses
   logic [7:0] bad [2] = '{8'h44, 8'ha8}; // step commands aimed at terminal registers
   int num_errors = 0;
   int num_checks = 0;
   localparam logic [8:0] mid = quad_pot_pkg::wiper_mid_8bit;
   quad_pot_regs u_quad_pot_regs (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .sdi(sdi),
      .reset_pin_n(reset_pin_n), .supply_below_trip(supply_below_trip), .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n), .wiper_pos_0(wp0), .wiper_pos_1(wp1), .wiper_pos_2(wp2),
      .wiper_pos_3(wp3), .net_shutdown_force(sdf), .net_term_a_connect(tac),
      .net_wiper_connect(twc), .net_term_b_connect(tbc), .cmd_error(cmd_error));
   spi_host_model u_spi_host_model (.clk(clk), .sdo_out(sdo_out), .cs_n(cs_n), .sck(sck),
      .sdi(sdi));
   // 25 MHz system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ===========================================================
   // tasks
   // ===========================================================
   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got_v);
      num_checks++;
      if (got_v !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got_v);
      end
   endtask
   // one whole frame; got keeps the last ten bits seen on sdo
   task automatic xfer(input logic [15:0] bits, input int n);
      u_spi_host_model.cs_lo();
      u_spi_host_model.shift(bits, n, rd);
      u_spi_host_model.cs_hi();
      got = rd[9:0];
   endtask
   task automatic check_defaults();
      check("wiper0", {1'b0, mid}, {1'b0, wp0});
      check("wiper1", {1'b0, mid}, {1'b0, wp1});
      check("wiper2", {1'b0, mid}, {1'b0, wp2});
      check("wiper3", {1'b0, mid}, {1'b0, wp3});
      check("net sd a", 10'h0ff, {2'b00, sdf, tac});
      check("net w b", 10'h0ff, {2'b00, twc, tbc});
      check("error", 10'h000, {9'h000, cmd_error});
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // hang guard, well beyond the expected run of a few thousand clocks
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      stop_test();
   end
   // ===========================================================
   // test sequence
   // ===========================================================
   initial begin
      rst_n = 1'b0;
      reset_pin_n = 1'b1;
      supply_below_trip = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      check_defaults();
      // every address read once; reserved ones flag and answer low
      for (int a = 0; a < 16; a++) begin
         rsv = !(a inside {0, 1, 4, 6, 7, 10});
         xfer({a[3:0], 12'hc00}, 16);
         check("read error", {9'h000, rsv}, {9'h000, cmd_error});
         check("read data", rsv ? 10'h000 : (a inside {4, 10}) ? 10'h3ff : {1'b1, mid},
            got);
      end
      foreach (wadr[i]) xfer({wadr[i], 3'h0, 9'h0f0 + 9'(i)}, 16);
      foreach (wadr[i]) begin
         xfer({wadr[i], 12'hc00}, 16);
         check("wiper read", {1'b1, 9'h0f0 + 9'(i)}, got);
      end
      check("wiper3 pin", 10'h0f3, {1'b0, wp3});
      // clip above full scale, no step past the ends
      xfer({4'h0, 3'h0, 9'h1ab}, 16);
      check("clip", 10'h100, {1'b0, wp0});
      xfer(16'h0004, 8);
      check("incr at full", 10'h100, {1'b0, wp0});
      xfer({4'h1, 3'h0, 9'h001}, 16);
      xfer(16'h1818, 16);
      check("decr at zero", 10'h000, {1'b0, wp1});
      xfer(16'h0014, 8);
      check("incr", 10'h001, {1'b0, wp1});
      // a failed step poisons the rest of the frame until select cycles
      foreach (bad[i]) begin
         u_spi_host_model.cs_lo();
         u_spi_host_model.shift({8'h00, bad[i]}, 8, rd);
         u_spi_host_model.shift({4'h0, 3'h0, 9'h055}, 16, rd);
         u_spi_host_model.cs_hi();
         check("step error", 10'h001, {9'h000, cmd_error});
         check("ignored write", 10'h100, {1'b0, wp0});
         u_spi_host_model.cs_lo();
         check("error cleared", 10'h000, {9'h000, cmd_error});
         u_spi_host_model.cs_hi();
      end
      // terminal value only lands with the last bit
      u_spi_host_model.cs_lo();
      u_spi_host_model.shift(16'h40a5 >> 1, 15, rd);
      check("before done", 10'h00f, {6'h00, twc});
      u_spi_host_model.shift(16'h0001, 1, rd);
      check("low sd a", 10'h0ed, {2'b00, sdf, tac});
      check("low w b", 10'h0ed, {2'b00, twc, tbc});
      u_spi_host_model.cs_hi();
      xfer({4'ha, 3'h0, 9'h03c}, 16);
      check("high sd a", 10'h065, {2'b00, sdf, tac});
      check("high w b", 10'h0a9, {2'b00, twc, tbc});
      check("wiper kept", 10'h0f3, {1'b0, wp3});
      xfer(16'hac00, 16);
      check("fixed bit", 10'h33c, got);
      // reset pin: serial ignored, defaults forced
      @(posedge clk);
      reset_pin_n <= 1'b0;
      xfer({4'h6, 3'h0, 9'h011}, 16);
      check_defaults();
      @(posedge clk);
      reset_pin_n <= 1'b1;
      repeat (6) @(posedge clk);
      check_defaults();
      // supply trip and recovery
      xfer({4'h7, 3'h0, 9'h022}, 16);
      @(posedge clk);
      supply_below_trip <= 1'b1;
      xfer({4'h7, 3'h0, 9'h033}, 16);
      check("sdo released", 10'h001, {9'h000, sdo_oe_n});
      check_defaults();
      @(posedge clk);
      supply_below_trip <= 1'b0;
      repeat (6) @(posedge clk);
      check_defaults();
      xfer(16'h40a5, 16);
      check("rewrite", 10'h0ed, {2'b00, sdf, tac});
      stop_test();
   end
endmodule
